// >>> core/bscan_cell.sv
// Purpose: Two-stage boundary cell for one bidirectional pin
// Assumes: Strobes are one system clock long and never overlap
// Notes:   Value stage sits nearer the input end, control stage feeds serial_out
`timescale 1ns/1ps
module bscan_cell (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic clk_en_in,
  input  wire logic capture_en_in,
  input  wire logic shift_en_in,
  input  wire logic update_en_in,
  input  wire logic serial_in,
  input  wire logic cap_control_in,
  input  wire logic cap_value_in,
  output logic      serial_out,
  output logic      upd_control_out,
  output logic      upd_value_out
);

  logic stage_value;
  logic stage_control;

  // Capture or shift toward the low end, low bit leaves first
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage_value   <= 1'b0;
      stage_control <= 1'b0;
    end else if (clk_en_in && capture_en_in) begin
      stage_value   <= cap_value_in;
      stage_control <= cap_control_in;
    end else if (clk_en_in && shift_en_in) begin
      stage_value   <= serial_in;
      stage_control <= stage_value;
    end
  end

  // Update latches hold the values driven out under external test
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upd_control_out <= 1'b0;
      upd_value_out   <= 1'b0;
    end else if (clk_en_in && update_en_in) begin
      upd_control_out <= stage_control;
      upd_value_out   <= stage_value;
    end
  end

  assign serial_out = stage_control;

endmodule // bscan_cell

// >>> core/bscan_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the pin scan block
// Assumes: 8-bit register bus, 4-bit instruction register
// Notes:   Definitions only
`ifndef BSCAN_CFG_SVH
`define BSCAN_CFG_SVH

// Register offsets
`define BSC_ADDR_W          4
`define BSC_OFF_MCU_CONTROL 4'h0
`define BSC_OFF_RESET_SRC   4'h1
`define BSC_OFF_IRQ_STATUS  4'h2
`define BSC_OFF_IRQ_MASK    4'h3

// Control register fields
`define BSC_BIT_PORT_DIS    7
`define BSC_BIT_PULL_DIS    4
`define BSC_CTRL_RW_MASK    8'h13
`define BSC_CTRL_RESET      8'h00

// Reset source fields
`define BSC_BIT_TEST_RST    4
`define BSC_BIT_WDOG_RST    3
`define BSC_BIT_BOUT_RST    2
`define BSC_BIT_EXT_RST     1
`define BSC_BIT_PWR_RST     0
`define BSC_RSTSRC_RESET    8'h00

// Interrupt fields
`define BSC_IRQ_W           3
`define BSC_IRQ_CAPTURE     0
`define BSC_IRQ_UPDATE      1
`define BSC_IRQ_CORE_RST    2

// Instruction codes
`define BSC_IR_EXTEST       4'h0
`define BSC_IR_SAMPLE       4'h2
`define BSC_IR_CORE_RST     4'hC

// Timed double write window for the port disable bit
`define BSC_DIS_WINDOW_CYC  3'h4

`endif

// >>> core/bscan_pins.sv
// Purpose: Boundary scan of the port pins and reset pin, with test reset flag and port disable
// Assumes: Test port state levels and instruction arrive from the tap controller on its own clock
// Notes:   Operation summary below
// Operation
// - A core reset caused by a one in the test reset register sets the test reset flag at bit 4.
// - Power-on reset or a software write of zero clears the test reset flag.
// - The chain can drive and observe every port pin and observe the reset pin; analog controls are not in the chain.
// - Pull-ups are off while the instruction is external test or sample/preload.
// - Each pin carries control, output and input through a two-stage shift register.
// - Without scan, cell values follow input pin, port bit and direction, pull-up is derived.
// - Alternate functions sit outside the cell so capture sees the real pin level.
// - Digital controls into analog circuits are forced off during scan.
// - The system clock is not sent to a pin under external test or sample/preload.
// - Sample capture never samples the system clock on its pin.
// - An observe-only cell captures the active-low reset pin and never drives it.
// - Instruction code 0x0 selects the boundary chain between test in and test out.
// - Update under external test applies the update latches to the pins.
// - All scan registers shift least significant bit first in and out.
`timescale 1ns/1ps
`include "bscan_cfg.svh"
module bscan_pins import bscan_pkg::*; #(
  parameter int N_PINS   = 8,
  parameter int N_ANALOG = 2,
  parameter int CLK_PIN  = 7
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  clk_en_in,
  input  wire logic [`BSC_ADDR_W-1:0] addr_in,
  input  wire logic [7:0]            wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [7:0]            rdata_out,
  output logic                       irq_out,
  input  wire logic                  tck_in,
  input  wire logic                  tdi_in,
  input  wire logic                  capture_dr_in,
  input  wire logic                  shift_dr_in,
  input  wire logic                  update_dr_in,
  input  wire logic [3:0]            ir_in,
  output logic                       tdo_out,
  output logic                       jtag_port_disable_out,
  output logic                       core_reset_out,
  input  wire logic                  power_on_event_in,
  input  wire logic                  external_event_in,
  input  wire logic                  brownout_event_in,
  input  wire logic                  watchdog_event_in,
  input  wire logic                  reset_pin_b_in,
  input  wire logic [N_PINS-1:0]     port_output_bit_in,
  input  wire logic [N_PINS-1:0]     pin_direction_bit_in,
  input  wire logic [N_PINS-1:0]     pad_in,
  output logic      [N_PINS-1:0]     pad_out,
  output logic      [N_PINS-1:0]     pad_oe_out,
  output logic      [N_PINS-1:0]     pin_pullup_enable_out,
  input  wire logic                  clock_output_fuse_in,
  output logic                       clock_output_en_out,
  input  wire logic [N_ANALOG-1:0]   analog_ctrl_in,
  output logic      [N_ANALOG-1:0]   analog_ctrl_out
);

  localparam int LW = $bits(tap_link_t);
  localparam int SW = LW + N_PINS + 1;

  // Synchroniser for everything outside the clock domain
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic [SW-1:0] sync_c;
  logic [SW-1:0] sync_st;
  wire  [SW-1:0] raw_in   = {tck_in, tdi_in, capture_dr_in, shift_dr_in, update_dr_in, ir_in,
                             reset_pin_b_in, pad_in};
  wire  [SW-1:0] agree    = ~(sync_b ^ sync_c);
  wire  [SW-1:0] next_st  = (agree & sync_c) | (~agree & sync_st);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_a  <= '0;
      sync_b  <= '0;
      sync_c  <= '0;
      sync_st <= '0;
    end else if (clk_en_in) begin
      sync_a  <= raw_in;
      sync_b  <= sync_a;
      sync_c  <= sync_b;
      sync_st <= next_st;
    end
  end

  // Decoded link view
  tap_link_t link;
  tap_link_t link_old;
  assign link     = tap_link_t'(next_st[SW-1 -: LW]);
  assign link_old = tap_link_t'(sync_st[SW-1 -: LW]);
  wire              rst_pin_b = next_st[N_PINS];
  wire [N_PINS-1:0] pad_level = next_st[N_PINS-1:0];

  // Register file state
  logic [7:0]              mcu_control;
  logic [7:0]              reset_source_status;
  logic [`BSC_IRQ_W-1:0]   irq_status;
  logic [`BSC_IRQ_W-1:0]   irq_mask;
  logic                    port_dis;

  // Instruction decode, ignored entirely while the port is disabled
  wire tck_rise   = link.tck & ~link_old.tck & ~port_dis;
  wire tck_fall   = ~link.tck & link_old.tck & ~port_dis;
  wire ir_extest  = (link.ir == `BSC_IR_EXTEST) & ~port_dis;
  wire ir_sample  = (link.ir == `BSC_IR_SAMPLE) & ~port_dis;
  wire ir_corerst = (link.ir == `BSC_IR_CORE_RST) & ~port_dis;
  wire scan_sel   = ir_extest | ir_sample;
  wire cap_en     = tck_rise & link.capture_dr & scan_sel;
  wire shift_en   = tck_rise & link.shift_dr & scan_sel;
  wire upd_en     = tck_fall & link.update_dr & scan_sel;
  wire pull_dis   = mcu_control[`BSC_BIT_PULL_DIS];

  // Chain: pin cells low, reset observe cell on top
  logic              rst_cell;
  logic [N_PINS:0]   chain_link;
  logic [N_PINS-1:0] upd_control;
  logic [N_PINS-1:0] upd_value;
  logic [N_PINS-1:0] cap_value;
  assign chain_link[N_PINS] = rst_cell;

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_cell
      // Clock pin captures the port bit while the clock fuse is set, never the running clock
      if (gi == CLK_PIN) begin : g_clk
        assign cap_value[gi] = clock_output_fuse_in ? port_output_bit_in[gi] : pad_level[gi];
      end else begin : g_pad
        assign cap_value[gi] = pad_level[gi];       // Real pin level, alternates sit outside
      end
      bscan_cell u_cell (
        .clk_in          (clk_in),
        .rst_b_in        (rst_b_in),
        .clk_en_in       (clk_en_in),
        .capture_en_in   (cap_en),
        .shift_en_in     (shift_en),
        .update_en_in    (upd_en),
        .serial_in       (chain_link[gi+1]),
        .cap_control_in  (pin_direction_bit_in[gi]),
        .cap_value_in    (cap_value[gi]),
        .serial_out      (chain_link[gi]),
        .upd_control_out (upd_control[gi]),
        .upd_value_out   (upd_value[gi])
      );
    end
  endgenerate

  // Observe-only reset cell: captured, shifted, never driven back
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_cell <= 1'b0;
    end else if (clk_en_in && cap_en) begin
      rst_cell <= rst_pin_b;
    end else if (clk_en_in && shift_en) begin
      rst_cell <= link.tdi;
    end
  end

  // One-bit core reset register and bypass bit
  logic core_rst_reg;
  logic bypass_reg;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      core_rst_reg <= 1'b0;
      bypass_reg   <= 1'b0;
    end else if (clk_en_in && tck_rise && link.shift_dr) begin
      core_rst_reg <= ir_corerst ? link.tdi : core_rst_reg;
      bypass_reg   <= link.tdi;
    end else if (clk_en_in && tck_rise && link.capture_dr) begin
      bypass_reg   <= 1'b0;
    end
  end

  // Test out changes on the falling link edge, low bit first
  wire next_tdo = scan_sel ? chain_link[0] : (ir_corerst ? core_rst_reg : bypass_reg);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tdo_out <= 1'b0;
    end else if (clk_en_in && tck_fall) begin
      tdo_out <= next_tdo;
    end
  end

  // Pin drive: latches under external test, port logic otherwise
  wire [N_PINS-1:0] next_pad_oe   = ir_extest ? upd_control : pin_direction_bit_in;
  wire [N_PINS-1:0] next_pad_out  = ir_extest ? upd_value : port_output_bit_in;
  wire [N_PINS-1:0] next_pullup   = scan_sel ? '0 :
                                    ({N_PINS{~pull_dis}} & ~pin_direction_bit_in & port_output_bit_in);
  wire              next_clk_en   = clock_output_fuse_in & ~scan_sel;
  wire [N_ANALOG-1:0] next_analog = scan_sel ? '0 : analog_ctrl_in;

  // Outputs registered so pads see no decode glitches
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pad_oe_out            <= '0;
      pad_out               <= '0;
      pin_pullup_enable_out <= '0;
      clock_output_en_out   <= 1'b0;
      analog_ctrl_out       <= '0;
      core_reset_out        <= 1'b0;
    end else if (clk_en_in) begin
      pad_oe_out            <= next_pad_oe;
      pad_out               <= next_pad_out;
      pin_pullup_enable_out <= next_pullup;
      clock_output_en_out   <= next_clk_en;
      analog_ctrl_out       <= next_analog;
      core_reset_out        <= ir_corerst & core_rst_reg;
    end
  end

  // Bus decode
  wire wr_ctl   = wr_in && (addr_in == `BSC_OFF_MCU_CONTROL);
  wire wr_src   = wr_in && (addr_in == `BSC_OFF_RESET_SRC);
  wire wr_stat  = wr_in && (addr_in == `BSC_OFF_IRQ_STATUS);
  wire wr_mask  = wr_in && (addr_in == `BSC_OFF_IRQ_MASK);
  wire core_req = ir_corerst & core_rst_reg;

  // Timed double write guards the disable bit against stray stores
  dis_state_t dis_state;
  logic [2:0] dis_cnt;
  logic       dis_pend;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dis_state <= DIS_IDLE;
      dis_cnt   <= 3'h0;
      dis_pend  <= 1'b0;
      port_dis  <= 1'b0;
    end else if (clk_en_in) begin
      case (dis_state)
        DIS_IDLE: begin
          if (wr_ctl && (wdata_in[`BSC_BIT_PORT_DIS] != port_dis)) begin
            dis_state <= DIS_ARMED;
            dis_pend  <= wdata_in[`BSC_BIT_PORT_DIS];
            dis_cnt   <= `BSC_DIS_WINDOW_CYC;
          end
        end
        DIS_ARMED: begin
          if (wr_ctl) begin
            port_dis  <= (wdata_in[`BSC_BIT_PORT_DIS] == dis_pend) ? dis_pend : port_dis;
            dis_state <= DIS_IDLE;
          end else if (dis_cnt == 3'h0) begin
            dis_state <= DIS_IDLE;
          end else begin
            dis_cnt   <= dis_cnt - 3'h1;
          end
        end
        default: dis_state <= DIS_IDLE;
      endcase
    end
  end

  // Plain control bits; the disable bit mirrors the committed value
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mcu_control <= `BSC_CTRL_RESET;
    end else if (clk_en_in) begin
      mcu_control <= ((wr_ctl ? wdata_in : mcu_control) & `BSC_CTRL_RW_MASK)
                     | ({7'h00, port_dis} << `BSC_BIT_PORT_DIS);
    end
  end
  assign jtag_port_disable_out = mcu_control[`BSC_BIT_PORT_DIS];

  // Reset sources: zero written clears, a fresh event wins over the clear
  wire [7:0] src_events = {3'h0, core_req, watchdog_event_in, brownout_event_in,
                           external_event_in, power_on_event_in};
  wire [7:0] src_kept   = wr_src ? (reset_source_status & wdata_in) : reset_source_status;
  wire [7:0] src_por    = power_on_event_in ? ~(8'h01 << `BSC_BIT_TEST_RST) : 8'hFF;
  wire [7:0] next_src   = (src_kept & src_por) | src_events;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_source_status <= `BSC_RSTSRC_RESET;
    end else if (clk_en_in) begin
      reset_source_status <= next_src;
    end
  end

  // Sticky interrupt events, write one to clear, set wins
  logic core_req_old;
  wire [`BSC_IRQ_W-1:0] irq_ev   = {core_req & ~core_req_old, upd_en, cap_en};
  wire [`BSC_IRQ_W-1:0] next_irq = (irq_status & ~(wr_stat ? wdata_in[`BSC_IRQ_W-1:0] : '0)) | irq_ev;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_status   <= '0;
      irq_mask     <= '0;
      core_req_old <= 1'b0;
      irq_out      <= 1'b0;
    end else if (clk_en_in) begin
      irq_status   <= next_irq;
      irq_mask     <= wr_mask ? wdata_in[`BSC_IRQ_W-1:0] : irq_mask;
      core_req_old <= core_req;
      irq_out      <= |(next_irq & irq_mask);
    end
  end

  // Read data one cycle after the strobe, unmapped reads zero
  wire [7:0] rd_mux = (addr_in == `BSC_OFF_MCU_CONTROL) ? mcu_control :
                      (addr_in == `BSC_OFF_RESET_SRC)   ? reset_source_status :
                      (addr_in == `BSC_OFF_IRQ_STATUS)  ? {5'h00, irq_status} :
                      (addr_in == `BSC_OFF_IRQ_MASK)    ? {5'h00, irq_mask} : 8'h00;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
    end
  end

  // Checks
  test_flag_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && core_req |=> reset_source_status[`BSC_BIT_TEST_RST])
    else $error("test reset flag not set");
  test_flag_por_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && power_on_event_in && !core_req |=> !reset_source_status[`BSC_BIT_TEST_RST])
    else $error("test reset flag survived power-on");
  pullup_scan_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && scan_sel |=> pin_pullup_enable_out == '0)
    else $error("pull-up on during scan");
  pullup_rule_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && !scan_sel |=> pin_pullup_enable_out ==
      ($past({N_PINS{~pull_dis}}) & ~$past(pin_direction_bit_in) & $past(port_output_bit_in)))
    else $error("pull-up does not follow port settings");
  clock_pin_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && scan_sel |=> !clock_output_en_out)
    else $error("clock sent to pin during scan");
  analog_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && scan_sel |=> analog_ctrl_out == '0)
    else $error("analog control active during scan");
  extest_drive_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && ir_extest |=> pad_oe_out == $past(upd_control) && pad_out == $past(upd_value))
    else $error("pins not driven from update latches");
  normal_drive_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && !ir_extest |=> pad_oe_out == $past(pin_direction_bit_in)
      && pad_out == $past(port_output_bit_in))
    else $error("pins not driven from port logic");
  disabled_idle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && port_dis |=> $stable(tdo_out) && !core_reset_out)
    else $error("scan active while port disabled");
  cover_capture: cover property (@(posedge clk_in) disable iff (!rst_b_in) cap_en ##[1:200] shift_en);
  cover_update: cover property (@(posedge clk_in) disable iff (!rst_b_in) ir_extest && upd_en);
  cover_core_rst: cover property (@(posedge clk_in) disable iff (!rst_b_in) core_req);
  cover_disable: cover property (@(posedge clk_in) disable iff (!rst_b_in) $rose(port_dis));

endmodule // bscan_pins

// >>> core/bscan_pkg.sv
// Purpose: Types shared by the pin scan block
// Assumes: Link signals are sampled by the system clock
// Notes:   Numbers live in bscan_cfg.svh
package bscan_pkg;

  // Test link levels as seen after the synchroniser
  typedef struct packed {
    logic       tck;
    logic       tdi;
    logic       capture_dr;
    logic       shift_dr;
    logic       update_dr;
    logic [3:0] ir;
  } tap_link_t;

  // Timed double write of the port disable bit
  typedef enum logic [1:0] {
    DIS_IDLE  = 2'b01,
    DIS_ARMED = 2'b10
  } dis_state_t;

endpackage

// >>> verif/host_tap.sv
// Purpose: Behavioural test controller that drives the scan link
// Assumes: Link clock of 200 ns, still between frames
// Notes:   Levels change mid low phase so both link edges see them settled
`timescale 1ns/1ps
module host_tap (
  output logic       tck_out,
  output logic       tdi_out,
  output logic       cap_out,
  output logic       shift_out,
  output logic       upd_out,
  output logic [3:0] ir_out,
  input  wire logic  tdo_in
);
  // Idle link, clock low
  initial begin
    tck_out = 1'b0;
    tdi_out = 1'b0;
    cap_out = 1'b0;
    shift_out = 1'b0;
    upd_out = 1'b0;
    ir_out = 4'hF;
  end

  // One link period; data out taken well after the previous falling edge
  task tick(output logic t);
    #50 tck_out = 1'b1;
    #50 t = tdo_in;
    #50 tck_out = 1'b0;
    #50;
  endtask

  task set_ir(input logic [3:0] c);
    ir_out = c;
    #407;
  endtask

  // Capture, shift n bits, update
  task scan(input logic [3:0] c, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = 32'h0;
    set_ir(c);
    cap_out = 1'b1;
    tick(t);
    cap_out = 1'b0;
    shift_out = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi_out = din[i];
      tick(t);
      dout[i] = t;
    end
    // Released data line shows the inverse, not a held value
    shift_out = 1'b0;
    tdi_out = ~tdi_out;
    upd_out = 1'b1;
    tick(t);
    upd_out = 1'b0;
    #400;
  endtask
endmodule // host_tap

// >>> verif/test_bscan_pins.sv
// Purpose: Self-checking bench of the pin scan block
// Assumes: Clock pin 7 captures the port bit while the clock fuse is set
// Notes:   Expected values built from integers, never from outputs
`timescale 1ns/1ps
`include "bscan_cfg.svh"
module test_bscan_pins import bscan_pkg::*;;
  logic        clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, fuse = 1'b0, rpin_b = 1'b1;
  logic [3:0]  addr_in = 4'h0, ev = 4'h0, ir;
  logic [7:0]  wdata_in = 8'h00, rdata_out, port = 8'h00, dir = 8'h00, pad = 8'h00, pad_out, pad_oe, pull, r, st;
  logic [1:0]  ana = 2'h0, ana_out;
  logic        ce = 1'b1;
  logic        tck, tdi, cap, sh, upd, tdo, irq, dis, core_rst, clk_oe;
  logic [31:0] got, din, exp;
  int          mismatches = 0, n_tests = 0;

  initial forever #12.5 clk_in = ~clk_in;

  host_tap host_tap_inst (.tck_out(tck), .tdi_out(tdi), .cap_out(cap), .shift_out(sh), .upd_out(upd),
    .ir_out(ir), .tdo_in(tdo));

  bscan_pins bscan_pins_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(ce), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq), .tck_in(tck),
    .tdi_in(tdi), .capture_dr_in(cap), .shift_dr_in(sh), .update_dr_in(upd), .ir_in(ir), .tdo_out(tdo),
    .jtag_port_disable_out(dis), .core_reset_out(core_rst), .power_on_event_in(ev[0]),
    .external_event_in(ev[1]), .brownout_event_in(ev[2]), .watchdog_event_in(ev[3]),
    .reset_pin_b_in(rpin_b), .port_output_bit_in(port), .pin_direction_bit_in(dir), .pad_in(pad),
    .pad_out(pad_out), .pad_oe_out(pad_oe), .pin_pullup_enable_out(pull), .clock_output_fuse_in(fuse),
    .clock_output_en_out(clk_oe), .analog_ctrl_in(ana), .analog_ctrl_out(ana_out));

  task check(input string name, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, e, seen);
    end
  endtask

  // Bus cycles: one-cycle strobes, read data in the following cycle only
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, far beyond the expected run of some 17 us
  initial begin
    #2000000;
    mismatches++;
    test_done;
  end

  initial begin
    void'($urandom(32'h5dcb));
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    cyc(1);
    for (int a = 0; a < 5; a++) begin
      rd(a[3:0], r);
      check("reset value", r, 32'h0);
    end
    $display("test reset values done");

    // Normal mode: pins follow port logic, pull-up derived
    for (int k = 0; k < 4; k++) begin
      wr(`BSC_OFF_MCU_CONTROL, k[0] ? 8'h10 : 8'h00);
      port <= $urandom;
      dir <= $urandom;
      ana <= $urandom;
      fuse <= k[1];
      cyc(6);
      check("pullup", pull, ~dir & port & {8{~k[0]}});
      check("pad oe", pad_oe, dir);
      check("pad out", pad_out, port);
      check("clock out", clk_oe, k[1]);
      check("analog", ana_out, ana);
    end
    $display("test normal mode done");

    // External test then sample/preload over the whole chain
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      pad <= $urandom;
      rpin_b <= $urandom;
      dir <= $urandom;
      port <= $urandom;
      fuse <= 1'b1;
      cyc(8);
      exp = 32'h0;
      for (int i = 0; i < 8; i++) begin
        exp[2*i] = dir[i];
        exp[2*i+1] = (i == 7) ? port[7] : pad[i];
      end
      exp[16] = rpin_b;
      din = $urandom & 32'h1FFFF;
      host_tap_inst.scan(k ? `BSC_IR_SAMPLE : `BSC_IR_EXTEST, 17, din, got);
      check("chain", got, exp);
      check("scan pullup", pull, 32'h0);
      check("scan clock out", clk_oe, 32'h0);
      check("scan analog", ana_out, 32'h0);
      for (int i = 0; i < 8; i++) begin
        check("updated oe", pad_oe[i], k ? dir[i] : din[2*i]);
        check("updated out", pad_out[i], k ? port[i] : din[2*i+1]);
      end
    end
    $display("test scan done");

    // Capture and update events, masked then unmasked, then cleared
    rd(`BSC_OFF_IRQ_STATUS, r);
    check("irq status", r, 32'h3);
    check("masked irq", irq, 32'h0);
    wr(`BSC_OFF_IRQ_MASK, 8'h07);
    cyc(2);
    check("irq", irq, 32'h1);
    wr(`BSC_OFF_IRQ_STATUS, 8'h03);
    cyc(2);
    check("cleared irq", irq, 32'h0);
    // Clock enable low freezes the registers, so this write is lost
    @(posedge clk_in);
    ce <= 1'b0;
    wr(`BSC_OFF_IRQ_MASK, 8'h00);
    @(posedge clk_in);
    ce <= 1'b1;
    rd(`BSC_OFF_IRQ_MASK, r);
    check("frozen mask", r, 32'h7);
    $display("test interrupt done");

    // Core reset instruction sets the test flag; power-on clears it
    host_tap_inst.scan(`BSC_IR_CORE_RST, 1, 32'h1, got);
    cyc(6);
    check("core reset", core_rst, 32'h1);
    st = 8'h10;
    rd(`BSC_OFF_RESET_SRC, r);
    check("test flag", r, st);
    rd(`BSC_OFF_IRQ_STATUS, r);
    check("core irq status", r, 32'h4);
    host_tap_inst.set_ir(4'hF);
    cyc(6);
    check("core reset off", core_rst, 32'h0);
    wr(`BSC_OFF_RESET_SRC, 8'hFF);
    rd(`BSC_OFF_RESET_SRC, r);
    check("write one keeps", r, st);
    for (int e = 0; e < 4; e++) begin
      @(posedge clk_in);
      ev <= 4'h1 << e;
      @(posedge clk_in);
      ev <= 4'h0;
      if (e == 0)
        st = st & 8'hEF;
      st = st | (8'h01 << e);
      rd(`BSC_OFF_RESET_SRC, r);
      check("reset source", r, st);
    end
    wr(`BSC_OFF_RESET_SRC, 8'h00);
    rd(`BSC_OFF_RESET_SRC, r);
    check("flags cleared", r, 32'h0);
    $display("test reset source done");

    // Single write only arms; a timed double write commits
    wr(`BSC_OFF_MCU_CONTROL, 8'hFF);
    cyc(8);
    rd(`BSC_OFF_MCU_CONTROL, r);
    check("control", r, 32'h13);
    check("disable held", dis, 32'h0);
    wr(`BSC_OFF_MCU_CONTROL, 8'h80);
    wr(`BSC_OFF_MCU_CONTROL, 8'h80);
    cyc(1);
    check("disable", dis, 32'h1);
    rd(`BSC_OFF_MCU_CONTROL, r);
    check("control set", r, 32'h80);
    // Reset register still holds a one; a disabled port must ignore the instruction
    host_tap_inst.scan(`BSC_IR_CORE_RST, 1, 32'h1, got);
    cyc(6);
    check("disabled core reset", core_rst, 32'h0);
    $display("test port disable done");
    test_done;
  end
endmodule // test_bscan_pins
